// File: logic/pvtp_top.v
// data-enable timing checker and colour packer behind an axi4-lite slave
`timescale 1ns/100ps
`include "pvtp_defines.vh"

// How it works
// RULE1: host sends 480 active clocks per line
// RULE2: host blanking 60 to 120 clocks
// RULE3: host line total 540 to 600 clocks
// RULE4: host sends 2160 active lines
// RULE5: host vertical blanking 40 to 600 lines
// RULE6: host frame total 2200 to 2760 lines
// RULE7: host pixel clock 67 to 78 MHz
// RULE8: host line rate 121.8 to 140 kHz
// RULE9: host frame rate 47 to 63 Hz
// RULE10: timing from data enable, syncs ignored
// RULE11: host spread limited to 0.5 percent
// RULE12: lane skew within 5 unit intervals
// RULE13: sub-block skew within one enable period
// RULE14: unsigned gray, larger is brighter
// RULE15: 30-bit packing layout of packer word
// RULE16: 24-bit packing layout of packer word
// RULE17: host signals idle before panel supply
// RULE18: host waits one second before repower
// RULE19: host drives data low when unpowered
// RULE20: depth select high means 10-bit
// RULE21: division input low means undivided
// RULE22: no input shows black or pattern
// RULE23: host zeros upper byte in 24-bit
module pvtp_top (
    // system
    input  wire        clk,
    input  wire        reset,
    // link side pins
    input  wire        link_clk,
    input  wire        link_de,
    input  wire        link_hsync,
    input  wire        link_vsync,
    input  wire [31:0] link_data,
    // axi4-lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // pixel out, 10 bits per colour
    output reg  [9:0]  pix_red,
    output reg  [9:0]  pix_green,
    output reg  [9:0]  pix_blue,
    output reg         pix_valid
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation; syncs are not even sampled
    wire [33:0] sync_q;
    wire        lclk_s = sync_q[33];
    wire        de_s   = sync_q[32];
    wire [31:0] data_s = sync_q[31:0];

    // RULE10: syncs ignored
    pvtp_sync2 #(.WIDTH(34)) u_sync (
        .clk  (clk),
        .din  ({link_clk, link_de, link_data}),
        .dout (sync_q)
    );

    reg         lclk_d_r;
    wire        ledge = lclk_s & ~lclk_d_r;   // one-cycle enable per link clock

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg  [31:0] ctrl_r;
    reg  [3:0]  status_r;
    reg  [11:0] hcnt_r;       // clocks in current line
    reg  [11:0] hact_r;       // active clocks in current line
    reg  [11:0] vact_r;       // active lines counted
    reg  [11:0] last_line_r;
    reg  [11:0] last_frame_r;
    reg         de_prev_r;
    reg  [11:0] idle_r;       // link clocks without enable
    reg  [9:0]  pat_r;

    wire        bit10  = ctrl_r[`PVTP_CTRL_BIT10];
    wire        patsel = ctrl_r[`PVTP_CTRL_PATSEL];
    wire        de_rise = ledge & de_s & ~de_prev_r;
    wire        no_input = (idle_r >= `PVTP_V_TOTAL_MAX);

    // line and frame measurement, all from data enable
    always @(posedge clk) begin
        lclk_d_r <= lclk_s;
        if (reset) begin
            de_prev_r    <= 1'b0;
            hcnt_r       <= 12'h000;
            hact_r       <= 12'h000;
            vact_r       <= 12'h000;
            last_line_r  <= 12'h000;
            last_frame_r <= 12'h000;
            idle_r       <= 12'h000;
            status_r     <= 4'h0;
        end else if (ledge) begin
            de_prev_r <= de_s;
            idle_r    <= de_s ? 12'h000 : (no_input ? idle_r : idle_r + 12'h001);
            status_r[`PVTP_ST_VALID] <= ~no_input;
            if (de_s)
                hact_r <= hact_r + 12'h001;
            // RULE10: line starts at enable rise
            if (de_rise) begin
                hcnt_r      <= 12'h001;
                hact_r      <= 12'h001;
                last_line_r <= hcnt_r;
                // RULE1: active width check
                if (vact_r != 12'h000 && hact_r != `PVTP_H_ACTIVE)
                    status_r[`PVTP_ST_HERR] <= 1'b1;
                // RULE3: line total check
                if (vact_r != 12'h000 &&
                    (hcnt_r < `PVTP_H_TOTAL_MIN || hcnt_r > `PVTP_H_TOTAL_MAX))
                    status_r[`PVTP_ST_HBERR] <= 1'b1;
                // frame start after long blank
                if (hcnt_r > `PVTP_H_TOTAL_MAX) begin
                    // RULE4: active line count check
                    if (vact_r != 12'h000 && vact_r != `PVTP_V_ACTIVE)
                        status_r[`PVTP_ST_VERR] <= 1'b1;
                    last_frame_r <= vact_r;
                    vact_r       <= 12'h001;
                end else begin
                    vact_r <= vact_r + 12'h001;
                end
            end else if (hcnt_r != 12'hfff) begin
                hcnt_r <= hcnt_r + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unpacker; 24-bit values are left aligned into 10 bits
    always @(posedge clk) begin
        if (reset) begin
            pix_red   <= 10'h000;
            pix_green <= 10'h000;
            pix_blue  <= 10'h000;
            pix_valid <= 1'b0;
            pat_r     <= 10'h000;
        end else if (ledge) begin
            pix_valid <= de_s | no_input;
            pat_r     <= pat_r + 10'h001;
            // RULE22: black or pattern without input
            if (no_input) begin
                pix_red   <= patsel ? pat_r : 10'h000;
                pix_green <= patsel ? ~pat_r : 10'h000;
                pix_blue  <= 10'h000;
            // RULE20: ten-bit select
            end else if (bit10) begin
                // RULE15: thirty-bit layout
                pix_red   <= {data_s[`PVTP_HI_R], data_s[`PVTP_LO_R]};
                pix_green <= {data_s[`PVTP_HI_G], data_s[`PVTP_LO_G]};
                pix_blue  <= {data_s[`PVTP_HI_B], data_s[`PVTP_LO_B]};
            end else begin
                // RULE16: twenty-four-bit layout
                // RULE14: unsigned, scale preserved
                pix_red   <= {data_s[`PVTP_HI_R], 2'h0};
                pix_green <= {data_s[`PVTP_HI_G], 2'h0};
                pix_blue  <= {data_s[`PVTP_HI_B], 2'h0};
            end
        end else begin
            pix_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave; write takes both channels then answers
    reg        aw_got_r;
    reg        w_got_r;
    reg [3:0]  aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;

    always @(posedge clk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PVTP_RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            aw_addr_r     <= 4'h0;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            ctrl_r        <= `PVTP_CTRL_RESET;
        end else begin
            s_axi_awready <= ~aw_got_r & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
            s_axi_wready  <= ~w_got_r & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            // RULE21: division bit is stored and read back but drives no logic
            if (aw_got_r & w_got_r & ~s_axi_bvalid) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_r == `PVTP_REG_CTRL) begin
                    s_axi_bresp <= `PVTP_RESP_OKAY;
                    if (w_strb_r[0])
                        ctrl_r[2:0] <= w_data_r[2:0];
                end else if (aw_addr_r == `PVTP_REG_STATUS) begin
                    s_axi_bresp <= `PVTP_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `PVTP_RESP_SLVERR;
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel; status sticky bits are not cleared by reads
    always @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PVTP_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `PVTP_RESP_OKAY;
                if (s_axi_araddr == `PVTP_REG_CTRL)
                    s_axi_rdata <= {29'h0, ctrl_r[2:0]};
                else if (s_axi_araddr == `PVTP_REG_STATUS)
                    s_axi_rdata <= {28'h0, status_r};
                else if (s_axi_araddr == `PVTP_REG_LINE)
                    s_axi_rdata <= {20'h0, last_line_r};
                else if (s_axi_araddr == `PVTP_REG_FRAME)
                    s_axi_rdata <= {20'h0, last_frame_r};
                else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `PVTP_RESP_SLVERR;
                end
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // pvtp_top

// File: logic/pvtp_defines.vh
// constants for the panel video timing packer
`ifndef PVTP_DEFINES_VH
`define PVTP_DEFINES_VH
// register byte offsets
`define PVTP_REG_CTRL      4'h0
`define PVTP_REG_STATUS    4'h4
`define PVTP_REG_LINE      4'h8
`define PVTP_REG_FRAME     4'hc
// control field positions
`define PVTP_CTRL_BIT10    0
`define PVTP_CTRL_DIV2     1
`define PVTP_CTRL_PATSEL   2
`define PVTP_CTRL_RESET    32'h0000_0000
// packer word fields
`define PVTP_HI_R          7:0
`define PVTP_HI_G          15:8
`define PVTP_HI_B          23:16
`define PVTP_LO_B          27:26
`define PVTP_LO_G          29:28
`define PVTP_LO_R          31:30
// timing limits in link clock cycles and lines
`define PVTP_H_ACTIVE      12'd480
`define PVTP_H_BLANK_MIN   12'd60
`define PVTP_H_BLANK_MAX   12'd120
`define PVTP_H_TOTAL_MIN   12'd540
`define PVTP_H_TOTAL_MAX   12'd600
`define PVTP_V_ACTIVE      12'd2160
`define PVTP_V_TOTAL_MIN   12'd2200
`define PVTP_V_TOTAL_MAX   12'd2760
// status bits
`define PVTP_ST_HERR       0
`define PVTP_ST_VERR       1
`define PVTP_ST_VALID      2
`define PVTP_ST_HBERR      3
// axi responses
`define PVTP_RESP_OKAY     2'h0
`define PVTP_RESP_SLVERR   2'h2
`endif

// File: logic/pvtp_sync2.v
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module pvtp_sync2 #(
    parameter WIDTH = 1
) (
    // clock
    input  wire             clk,
    // bundle in and out
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta_r;

    // first stage is read by the second only
    always @(posedge clk) begin
        meta_r <= din;
        dout   <= meta_r;
    end
endmodule // pvtp_sync2

// File: tb/pvtp_monitor.sv
// assertion checker watching the packer top ports
`timescale 1ns/100ps
module pvtp_monitor (
    // system
    input wire        clk,
    input wire        reset,
    input wire        link_clk,
    // register bus
    input wire [3:0]  s_axi_awaddr,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // pixels
    input wire        pix_valid,
    input wire [9:0]  pix_red
);
    reg       mode_r;
    reg       lclk_r;
    reg [3:0] age_r;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    // shadow of depth select; age runs through reset so a late edge is still seen
    always @(posedge clk) begin
        lclk_r <= link_clk;
        age_r <= (link_clk && !lclk_r) ? 4'h0 : ((age_r == 4'hf) ? age_r : age_r + 4'h1);
        if (reset)
            mode_r <= 1'b0;
        else if (s_axi_awready && s_axi_awaddr == 4'h0)
            mode_r <= s_axi_wdata[0];
    end
    ////////////////////////////////////////
    property p_age; pix_valid |-> age_r < 4'h8; endproperty
    a_age: assert property (p_age) else $error("pixel pulse far from link edge");
    property p_depth8; pix_valid && !mode_r |-> pix_red[1:0] == 2'h0; endproperty
    a_depth8: assert property (p_depth8) else $error("low red bits in 8-bit mode");
    property p_pulse; pix_valid |=> !pix_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("pixel pulse too long");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_rans; s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bans; s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
    a_bans: assert property (p_bans) else $error("write answer late");
    property p_rst; disable iff (1'b0) reset |=> !pix_valid && !s_axi_bvalid && !s_axi_rvalid; endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule // pvtp_monitor
bind pvtp_top pvtp_monitor u_pvtp_monitor (
    .clk(clk), .reset(reset), .link_clk(link_clk), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pix_valid(pix_valid), .pix_red(pix_red)
);

// File: tb/pvtp_host_model.sv
// host video source model driving the link pins
`timescale 1ns/100ps
module pvtp_host_model (
    // link pins
    output reg        link_clk,
    output reg        link_de,
    output reg        link_hsync,
    output reg        link_vsync,
    output reg [31:0] link_data
);
    ////////////////////////////////////////
    // data and controls low before any line
    initial begin
        link_clk = 1'b0;
        link_de = 1'b0;
        link_hsync = 1'b0;
        link_vsync = 1'b0;
        link_data = 32'h0;
    end
    // steady clock, no spread
    // the period is stretched so lines fit the run; line and frame rates scale with it
    always #16 link_clk = ~link_clk;
    // one lane word, so no skew
    // single lines only; full frames and supply cycling are out of reach
    // one line; syncs wiggle, blanking data is not the stale word
    task send_line(input [31:0] word, input [11:0] act, input [11:0] blank);
        integer i;
        begin
            for (i = 0; i < act + blank; i = i + 1) begin
                @(negedge link_clk);
                link_de = (i < act);
                link_data = (i < act) ? word : ~word;
                link_hsync = i[0];
                link_vsync = i[1];
            end
        end
    endtask
endmodule // pvtp_host_model

// File: tb/panel_video_timing_packer_test.sv
// self-checking bench for the packer top
`timescale 1ns/100ps
`include "pvtp_defines.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module panel_video_timing_packer_test;
    typedef struct packed {
        logic        m;
        logic [31:0] w;
        logic [29:0] rgb;
    } pvtp_row_t;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pix_valid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata, link_data;
    wire  [9:0]  pix_red, pix_green, pix_blue;
    wire         link_clk, link_de, link_hsync, link_vsync;
    int          fails = 0;
    int          n_checks = 0;
    logic [31:0] d;
    logic [1:0]  r;
    pvtp_row_t   rows [6];
    ////////////////////////////////////////
    pvtp_top u_pvtp_top (
        .clk(clk), .reset(reset), .link_clk(link_clk), .link_de(link_de), .link_hsync(link_hsync),
        .link_vsync(link_vsync), .link_data(link_data), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue),
        .pix_valid(pix_valid)
    );
    pvtp_host_model u_pvtp_host_model (
        .link_clk(link_clk), .link_de(link_de), .link_hsync(link_hsync),
        .link_vsync(link_vsync), .link_data(link_data)
    );
    always #2 clk = ~clk;
    ////////////////////////////////////////
    // write: both channels offered together, each dropped when taken
    task wr(input [3:0] a, input [31:0] v, output [1:0] resp);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin do @(posedge clk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
            begin do @(posedge clk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
        join
        while (s_axi_bvalid !== 1'b1) @(posedge clk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input [3:0] a, output [31:0] v, output [1:0] resp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task end_sim;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        // 8-bit rows keep the upper byte zero; 0x03 in the top byte is don't-care
        rows = '{'{1'b1, 32'hffff_ffff, 30'h3fff_ffff}, '{1'b1, 32'h4000_0001, {10'h005, 20'h0}},
                 '{1'b1, 32'h2400_8000, {10'h0, 10'h202, 10'h001}}, '{1'b1, 32'h0300_0000, 30'h0},
                 '{1'b0, 32'h0012_3456, {10'h158, 10'h0d0, 10'h048}}, '{1'b0, 32'h00ff_0080, {10'h200, 10'h0, 10'h3fc}}};
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(`PVTP_REG_CTRL, d, r);
        `CHK(d, `PVTP_CTRL_RESET)
        `CHK(r, `PVTP_RESP_OKAY)
        foreach (rows[i]) begin
            wr(`PVTP_REG_CTRL, {31'h0, rows[i].m}, r);
            fork
                u_pvtp_host_model.send_line(rows[i].w, 12'd480, 12'd70);
                begin
                    repeat (40) @(posedge clk);
                    do @(negedge clk); while (pix_valid !== 1'b1);
                    `CHK({pix_red, pix_green, pix_blue}, rows[i].rgb)
                end
            join
        end
        // back-to-back clean lines, then a short active line and a short total
        repeat (3) u_pvtp_host_model.send_line(32'h0, 12'd480, 12'd70);
        rd(`PVTP_REG_LINE, d, r);
        `CHK(d, 32'd550)
        rd(`PVTP_REG_STATUS, d, r);
        `CHK(d & 32'h5, 32'h4)
        u_pvtp_host_model.send_line(32'h0, 12'd479, 12'd71);
        u_pvtp_host_model.send_line(32'h0, 12'd480, 12'd40);
        u_pvtp_host_model.send_line(32'h0, 12'd480, 12'd70);
        rd(`PVTP_REG_STATUS, d, r);
        `CHK(d & 32'h9, 32'h9)
        // read-only place refuses, control bits read back
        wr(`PVTP_REG_LINE, 32'h0, r);
        `CHK(r, `PVTP_RESP_SLVERR)
        wr(`PVTP_REG_CTRL, 32'h7, r);
        rd(`PVTP_REG_CTRL, d, r);
        `CHK(d, 32'h7)
        // idle link: pattern while selected, then black once deselected
        do @(negedge clk); while (pix_valid !== 1'b1);
        `CHK(pix_green, ~pix_red)
        `CHK(pix_blue, 10'h000)
        rd(`PVTP_REG_STATUS, d, r);
        `CHK(d & 32'h4, 32'h0)
        wr(`PVTP_REG_CTRL, 32'h1, r);
        repeat (20) @(posedge clk);
        do @(negedge clk); while (pix_valid !== 1'b1);
        `CHK({pix_red, pix_green, pix_blue}, 30'h0)
        // unaligned read is refused with zero data
        rd(4'h2, d, r);
        `CHK(r, `PVTP_RESP_SLVERR)
        `CHK(d, 32'h0)
        // second reset in mid-run
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(`PVTP_REG_CTRL, d, r);
        `CHK(d, `PVTP_CTRL_RESET)
        rd(`PVTP_REG_STATUS, d, r);
        `CHK(d & 32'h9, 32'h0)
        end_sim;
    end
    // watchdog well past the expected run length
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        end_sim;
    end
endmodule // panel_video_timing_packer_test
